// file: rtl/rpf_pkg.sv
// Constants for the raster polarity, sync edge and partial-area fill block.
// ====================================================================
package rpf_pkg;

    // ====================================================================
    // Register map
    localparam logic [7:0] RPF_OFS_PARTIAL = 8'h00;
    localparam logic [7:0] RPF_OFS_CONTROL = 8'h04;
    localparam logic [7:0] RPF_OFS_STATUS = 8'h08;
    localparam logic [31:0] RPF_PARTIAL_RESET = 32'h0000_0000;

    // ====================================================================
    // Field positions of the partial display control register
    localparam int RPF_PA_ENABLE_BIT = 31;
    localparam int RPF_PA_ABOVE_BIT = 29;
    localparam int RPF_PA_THR_LSB = 16;
    localparam int RPF_PA_FILL_LSB = 4;
    localparam logic [31:0] RPF_PARTIAL_MASK = 32'hA3FF_FFF0;

    // ====================================================================
    // Field positions of the output control register
    localparam int RPF_CT_OVERRIDE_BIT = 25;
    localparam int RPF_CT_EDGE_SEL_BIT = 24;
    localparam int RPF_CT_OE_INV_BIT = 23;
    localparam int RPF_CT_PCLK_INV_BIT = 22;
    localparam int RPF_CT_LSYNC_INV_BIT = 21;
    localparam int RPF_CT_ACTIVE_BIT = 0;
    localparam logic [31:0] RPF_CONTROL_MASK = 32'h03E0_0001;

    // ====================================================================
    // Field positions of the status register
    localparam int RPF_ST_UNDERFLOW_BIT = 0;
    localparam int RPF_ST_VIDEO_BIT = 1;
    localparam int RPF_ST_LINE_LSB = 16;

    // ====================================================================
    // Widths and buffering
    localparam int RPF_LINE_W = 10;
    localparam int RPF_FILL_W = 12;
    localparam int RPF_DATA_W = 16;
    localparam int RPF_FIFO_DEPTH = 16;

endpackage : rpf_pkg

// file: rtl/rpf_top.sv
// Pixel buffer and raster output stage with polarity, edge and partial-area control.
//
// Chosen here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// ====================================================================
// Pixel FIFO
module rpf_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign in_ready = (count_q != (AW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_ptr_q];

    always_ff @(posedge hclk)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : rpf_fifo

// ====================================================================
// Raster output stage
module rpf_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic pix_clk_in,
    input wire logic line_sync_raw,
    input wire logic frame_sync_raw,
    input wire logic data_active_raw,
    input wire logic [9:0] line_index,
    input wire logic [9:0] panel_line_count,
    input wire logic pix_valid,
    output logic pix_ready,
    input wire logic [15:0] pix_data,
    output logic line_fetch_enable,
    output logic pixel_clock_pin,
    output logic line_sync_pin,
    output logic frame_sync_pin,
    output logic bias_enable_pin,
    output logic [15:0] lcd_data
);

    // ====================================================================
    // Register bus
    logic [31:0] partial_q;
    logic [31:0] control_q;
    logic underflow_q;
    logic wr_pend_q;
    logic [7:0] addr_q;
    logic addr_phase;
    logic underflow_set;
    logic video_now;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_phase = hsel && hready && htrans[1] && (hsize == 3'h2);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end
        else if (hready)
        begin
            wr_pend_q <= addr_phase && hwrite;
            addr_q <= addr_phase ? haddr[7:0] : 8'hFF;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            partial_q <= rpf_pkg::RPF_PARTIAL_RESET;
            control_q <= 32'h0000_0000;
        end
        else if (wr_pend_q)
        begin
            if (addr_q == rpf_pkg::RPF_OFS_PARTIAL)
            begin
                partial_q <= hwdata & rpf_pkg::RPF_PARTIAL_MASK;
            end
            if (addr_q == rpf_pkg::RPF_OFS_CONTROL)
            begin
                control_q <= hwdata & rpf_pkg::RPF_CONTROL_MASK;
            end
        end
    end

    // A new underflow in the clearing cycle survives the clear.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            underflow_q <= 1'b0;
        end
        else if (underflow_set)
        begin
            underflow_q <= 1'b1;
        end
        else if (wr_pend_q && addr_q == rpf_pkg::RPF_OFS_STATUS
                 && hwdata[rpf_pkg::RPF_ST_UNDERFLOW_BIT])
        begin
            underflow_q <= 1'b0;
        end
    end

    always_comb
    begin
        hrdata = 32'h0000_0000;
        unique case (addr_q)
            rpf_pkg::RPF_OFS_PARTIAL: hrdata = partial_q;
            rpf_pkg::RPF_OFS_CONTROL: hrdata = control_q;
            rpf_pkg::RPF_OFS_STATUS:
            begin
                hrdata[rpf_pkg::RPF_ST_UNDERFLOW_BIT] = underflow_q;
                hrdata[rpf_pkg::RPF_ST_VIDEO_BIT] = video_now;
                hrdata[rpf_pkg::RPF_ST_LINE_LSB +: rpf_pkg::RPF_LINE_W] = line_index;
            end
            default: hrdata = 32'h0000_0000;
        endcase
    end

    // ====================================================================
    // Configuration fields
    logic pa_enable;
    logic pa_above;
    logic [9:0] pa_thr;
    logic [11:0] pa_fill;
    logic hv_override;
    logic hv_edge_sel;
    logic oe_invert;
    logic pclk_invert;
    logic lsync_invert;
    logic active_mode;

    assign pa_enable = partial_q[rpf_pkg::RPF_PA_ENABLE_BIT];
    assign pa_above = partial_q[rpf_pkg::RPF_PA_ABOVE_BIT];
    assign pa_thr = partial_q[rpf_pkg::RPF_PA_THR_LSB +: rpf_pkg::RPF_LINE_W];
    assign pa_fill = partial_q[rpf_pkg::RPF_PA_FILL_LSB +: rpf_pkg::RPF_FILL_W];
    assign hv_override = control_q[rpf_pkg::RPF_CT_OVERRIDE_BIT];
    assign hv_edge_sel = control_q[rpf_pkg::RPF_CT_EDGE_SEL_BIT];
    assign oe_invert = control_q[rpf_pkg::RPF_CT_OE_INV_BIT];
    assign pclk_invert = control_q[rpf_pkg::RPF_CT_PCLK_INV_BIT];
    assign lsync_invert = control_q[rpf_pkg::RPF_CT_LSYNC_INV_BIT];
    assign active_mode = control_q[rpf_pkg::RPF_CT_ACTIVE_BIT];

    // ====================================================================
    // Video region decision
    function automatic logic rpf_in_video(input logic en, input logic above,
                                          input logic [9:0] thr, input logic [9:0] lpc,
                                          input logic [9:0] line);
        logic r;
        r = 1'b1;
        if (!en)
        begin
            r = 1'b1;
        end
        else if (thr > lpc)
        begin
            r = !above;
        end
        else if (above)
        begin
            r = (line > thr);
        end
        else
        begin
            r = (line <= thr);
        end
        return r;
    endfunction : rpf_in_video

    assign video_now = rpf_in_video(pa_enable, pa_above, pa_thr, panel_line_count, line_index);

    // The fetch channel is told per line so fill lines never touch memory.
    assign line_fetch_enable = video_now;

    // ====================================================================
    // Pixel clock sampling and edge choice
    logic pclk_s1_q;
    logic pclk_s2_q;
    logic pclk_s3_q;
    logic pclk_rise;
    logic pclk_fall;
    logic data_edge;
    logic sync_edge;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pclk_s1_q <= 1'b0;
            pclk_s2_q <= 1'b0;
            pclk_s3_q <= 1'b0;
        end
        else
        begin
            pclk_s1_q <= pix_clk_in;
            pclk_s2_q <= pclk_s1_q;
            pclk_s3_q <= pclk_s2_q;
        end
    end

    assign pclk_rise = pclk_s2_q && !pclk_s3_q;
    assign pclk_fall = !pclk_s2_q && pclk_s3_q;
    assign pixel_clock_pin = pclk_s3_q;
    assign data_edge = pclk_invert ? pclk_fall : pclk_rise;

    always_comb
    begin
        if (hv_override)
        begin
            sync_edge = hv_edge_sel ? pclk_rise : pclk_fall;
        end
        else
        begin
            sync_edge = pclk_invert ? pclk_rise : pclk_fall;
        end
    end

    // ====================================================================
    // Sync outputs
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            line_sync_pin <= 1'b0;
            frame_sync_pin <= 1'b0;
        end
        else if (sync_edge)
        begin
            line_sync_pin <= line_sync_raw ^ lsync_invert;
            frame_sync_pin <= frame_sync_raw;
        end
    end

    // ====================================================================
    // Pixel data and enable
    logic fifo_valid;
    logic fifo_pop;
    logic [15:0] fifo_data;
    logic want_video;

    assign want_video = data_edge && data_active_raw && video_now;
    assign fifo_pop = want_video && fifo_valid;
    assign underflow_set = want_video && !fifo_valid;

    rpf_fifo #(
        .WIDTH(rpf_pkg::RPF_DATA_W),
        .DEPTH(rpf_pkg::RPF_FIFO_DEPTH)
    ) u_fifo (
        .hclk(hclk),
        .hresetn(hresetn),
        .in_valid(pix_valid),
        .in_ready(pix_ready),
        .in_data(pix_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // An empty buffer repeats the last pixel; the sticky flag shows it.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lcd_data <= 16'h0000;
        end
        else if (data_edge)
        begin
            if (!data_active_raw)
            begin
                lcd_data <= 16'h0000;
            end
            else if (!video_now)
            begin
                lcd_data <= {4'h0, pa_fill};
            end
            else if (fifo_valid)
            begin
                lcd_data <= fifo_data;
            end
        end
    end

    // The enable moves on the data edge so it frames exactly the driven pixels.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bias_enable_pin <= 1'b0;
        end
        else if (data_edge)
        begin
            if (active_mode)
            begin
                bias_enable_pin <= data_active_raw ^ oe_invert;
            end
            else
            begin
                bias_enable_pin <= data_active_raw;
            end
        end
    end

    // ====================================================================
    // Assertions
    property p_line_pol;
        @(posedge hclk) disable iff (!hresetn)
        sync_edge |=> line_sync_pin == $past(line_sync_raw ^ lsync_invert);
    endproperty
    a_line_pol: assert property (p_line_pol) else $error("line sync polarity wrong");

    property p_data_edge;
        @(posedge hclk) disable iff (!hresetn)
        $changed(lcd_data) |-> $past(pclk_invert ? pclk_fall : pclk_rise);
    endproperty
    a_data_edge: assert property (p_data_edge) else $error("data off launch edge");

    property p_bias_active;
        @(posedge hclk) disable iff (!hresetn)
        (data_edge && active_mode) |=> bias_enable_pin == $past(data_active_raw ^ oe_invert);
    endproperty
    a_bias_active: assert property (p_bias_active) else $error("enable polarity wrong");

    property p_bias_passive;
        @(posedge hclk) disable iff (!hresetn)
        (data_edge && !active_mode) |=> bias_enable_pin == $past(data_active_raw);
    endproperty
    a_bias_passive: assert property (p_bias_passive) else $error("passive enable inverted");

    property p_bias_frames_data;
        @(posedge hclk) disable iff (!hresetn)
        $changed(bias_enable_pin) |-> $past(data_edge);
    endproperty
    a_bias_frames_data: assert property (p_bias_frames_data) else $error("enable off edge");

    property p_sync_default;
        @(posedge hclk) disable iff (!hresetn)
        (!$past(hv_override) && $changed(line_sync_pin))
            |-> $past(pclk_invert ? pclk_rise : pclk_fall);
    endproperty
    a_sync_default: assert property (p_sync_default) else $error("sync not opposite data");

    property p_sync_override;
        @(posedge hclk) disable iff (!hresetn)
        ($past(hv_override) && !$past(hv_edge_sel) && $changed(frame_sync_pin))
            |-> $past(pclk_fall);
    endproperty
    a_sync_override: assert property (p_sync_override) else $error("sync not on falling");

    property p_disabled_full;
        @(posedge hclk) disable iff (!hresetn)
        !pa_enable |-> line_fetch_enable;
    endproperty
    a_disabled_full: assert property (p_disabled_full) else $error("fill while disabled");

    property p_fill_value;
        @(posedge hclk) disable iff (!hresetn)
        (data_edge && data_active_raw && !video_now) |=>
            lcd_data == {4'h0, $past(pa_fill)} && !$past(fifo_pop);
    endproperty
    a_fill_value: assert property (p_fill_value) else $error("fill pixel wrong");

    property p_beyond_panel;
        @(posedge hclk) disable iff (!hresetn)
        (pa_enable && pa_thr > panel_line_count) |-> line_fetch_enable == !pa_above;
    endproperty
    a_beyond_panel: assert property (p_beyond_panel) else $error("beyond panel wrong");

endmodule : rpf_top

`default_nettype wire

// file: test/rpf_panel.sv
// Behavioural display panel that latches pixels from the raster port.
`timescale 1ns/1ps
`default_nettype none

// ====================================================================
// Panel model
module rpf_panel (
    input wire logic pixel_clock_pin,
    input wire logic bias_enable_pin,
    input wire logic [15:0] lcd_data,
    input wire logic launch_on_fall,
    input wire logic enable_low,
    output var logic [15:0] last_px
);
    // Latching on the edge opposite the launch edge keeps half a pixel period of margin.
    initial
    begin
        last_px = 16'h0000;
    end
    always @(pixel_clock_pin)
    begin
        if (pixel_clock_pin === launch_on_fall && (bias_enable_pin ^ enable_low) === 1'b1)
        begin
            last_px <= lcd_data;
        end
    end
endmodule : rpf_panel
`default_nettype wire

// file: test/raster_polarity_and_partial_fill_test.sv
// Self-checking bench for the raster polarity, sync edge and partial-area block.
`timescale 1ns/1ps
`default_nettype none

module raster_polarity_and_partial_fill_test;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic pix_clk_in, line_sync_raw, frame_sync_raw, data_active_raw, pix_valid, pix_ready;
    logic [9:0] line_index, panel_line_count, thr, ln;
    logic [15:0] pix_data, lcd_data, last_px, seed, lastw;
    logic line_fetch_enable, pixel_clock_pin, line_sync_pin, frame_sync_pin, bias_enable_pin;
    logic ipc_cfg, oe_cfg, en, ab, v;
    logic [11:0] fill;
    logic [15:0] q[$];
    int n_fail, checks, cycles;

    rpf_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pix_clk_in(pix_clk_in),
        .line_sync_raw(line_sync_raw), .frame_sync_raw(frame_sync_raw),
        .data_active_raw(data_active_raw), .line_index(line_index),
        .panel_line_count(panel_line_count), .pix_valid(pix_valid), .pix_ready(pix_ready),
        .pix_data(pix_data), .line_fetch_enable(line_fetch_enable),
        .pixel_clock_pin(pixel_clock_pin), .line_sync_pin(line_sync_pin),
        .frame_sync_pin(frame_sync_pin), .bias_enable_pin(bias_enable_pin), .lcd_data(lcd_data));

    rpf_panel panel (.pixel_clock_pin(pixel_clock_pin), .bias_enable_pin(bias_enable_pin),
        .lcd_data(lcd_data), .launch_on_fall(ipc_cfg), .enable_low(oe_cfg), .last_px(last_px));

    // ====================================================================
    // Helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    function automatic logic exp_video(input logic e, input logic a, input logic [9:0] t,
                                       input logic [9:0] lpc, input logic [9:0] l);
        if (!e)
            exp_video = 1'b1;
        else if (t > lpc)
            exp_video = !a;
        else if (a)
            exp_video = l > t;
        else
            exp_video = l <= t;
    endfunction : exp_video

    task automatic chk_bit(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word

    task automatic conclude();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task automatic cfg(input logic pixel_clock_invert, input logic ovr, input logic sel, input logic oe,
                       input logic lsi, input logic act);
        ipc_cfg = pixel_clock_invert;
        oe_cfg = oe;
        ahb(1'b1, rpf_pkg::RPF_OFS_CONTROL, {6'h00, ovr, sel, oe, pixel_clock_invert, lsi, 20'h00000, act});
    endtask : cfg

    task automatic part(input logic e, input logic a, input logic [9:0] t, input logic [11:0] f);
        ahb(1'b1, rpf_pkg::RPF_OFS_PARTIAL, {e, 1'b0, a, 3'h0, t, f, 4'h0});
    endtask : part

    task automatic raw(input logic ls, input logic fs, input logic da);
        @(posedge hclk);
        line_sync_raw <= ls;
        frame_sync_raw <= fs;
        data_active_raw <= da;
    endtask : raw

    // One pixel clock phase; the wait covers the two-flop sync plus edge detect.
    task automatic half();
        @(posedge hclk);
        pix_clk_in <= ~pix_clk_in;
        repeat (4) @(posedge hclk);
        @(negedge hclk);
    endtask : half

    task automatic push(input logic [15:0] w);
        @(posedge hclk);
        pix_valid <= 1'b1;
        pix_data <= w;
        do @(posedge hclk); while (pix_ready !== 1'b1);
        pix_valid <= 1'b0;
        q.push_back(w);
    endtask : push

    task automatic drain();
        while (q.size() > 0)
        begin
            half();
            chk_word("video pixel", {16'h0000, q.pop_front()}, {16'h0000, lcd_data});
            half();
        end
    endtask : drain

    // ====================================================================
    // Clock, watchdog and sequence
    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_fail++;
            conclude();
        end
    end

    initial
    begin
        {hresetn, hsel, hwrite, pix_clk_in, pix_valid, ipc_cfg, oe_cfg} = 7'h00;
        {line_sync_raw, frame_sync_raw, data_active_raw} = 3'h0;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        htrans = 2'h0;
        hsize = 3'h2;
        line_index = 10'h000;
        panel_line_count = 10'h00A;
        pix_data = 16'h0000;
        n_fail = 0;
        checks = 0;
        cycles = 0;
        seed = 16'h000A;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, rpf_pkg::RPF_OFS_PARTIAL, 32'h0);
        chk_word("partial reset", rpf_pkg::RPF_PARTIAL_RESET, rd);
        ahb(1'b1, rpf_pkg::RPF_OFS_PARTIAL, 32'hFFFFFFFF);
        ahb(1'b0, rpf_pkg::RPF_OFS_PARTIAL, 32'h0);
        chk_word("partial fields", rpf_pkg::RPF_PARTIAL_MASK, rd);
        ahb(1'b0, rpf_pkg::RPF_OFS_CONTROL, 32'h0);
        chk_word("control reset", 32'h00000000, rd);
        ahb(1'b1, rpf_pkg::RPF_OFS_CONTROL, 32'hFFFFFFFF);
        ahb(1'b0, rpf_pkg::RPF_OFS_CONTROL, 32'h0);
        chk_word("control fields", rpf_pkg::RPF_CONTROL_MASK, rd);
        ahb(1'b1, 8'h0C, 32'hFFFFFFFF);
        ahb(1'b0, 8'h0C, 32'h0);
        chk_word("unmapped read", 32'h00000000, rd);
        $display("test registers done");
        // Threshold beyond the panel with the region above fills every line.
        part(1'b1, 1'b1, 10'd12, 12'hA5C);
        for (int k = 0; k < 8; k++)
        begin
            cfg(k[0], k[1], k[2], 1'b0, 1'b0, 1'b1);
            raw(1'b0, 1'b0, 1'b0);
            half();
            half();
            raw(1'b1, 1'b1, 1'b1);
            half();
            chk_bit("line sync at rise", k[1] ? k[2] : k[0], line_sync_pin);
            chk_bit("frame sync at rise", k[1] ? k[2] : k[0], frame_sync_pin);
            chk_word("data at rise", k[0] ? 32'h0 : 32'h0A5C, {16'h0000, lcd_data});
            half();
            chk_bit("line sync at fall", 1'b1, line_sync_pin);
            chk_word("data at fall", 32'h0A5C, {16'h0000, lcd_data});
        end
        $display("test edges done");
        for (int j = 0; j < 8; j++)
        begin
            seed = lfsr(seed);
            cfg(1'b0, 1'b0, 1'b0, j[1], j[0], j[2]);
            raw(seed[0], 1'b0, seed[1]);
            half();
            half();
            chk_bit("line sync level", seed[0] ^ j[0], line_sync_pin);
            chk_bit("enable level", j[2] ? seed[1] ^ j[1] : seed[1], bias_enable_pin);
            chk_word("fill level", seed[1] ? 32'h0A5C : 32'h0, {16'h0000, lcd_data});
        end
        $display("test polarity done");
        @(posedge hclk);
        panel_line_count <= 10'd20;
        cfg(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        for (int i = 0; i < 24; i++)
        begin
            seed = lfsr(seed);
            en = (i < 4) ? 1'b1 : seed[0];
            ab = (i < 4) ? i[0] : seed[1];
            thr = (i < 4) ? (i[1] ? 10'd20 : 10'd2) : 10'd2 + 10'(seed[7:3]) % 10'd22;
            ln = (i < 4) ? thr : 10'(seed[15:8]) % 10'd21;
            fill = seed[15:4];
            part(en, ab, thr, fill);
            @(posedge hclk);
            line_index <= ln;
            @(negedge hclk);
            v = exp_video(en, ab, thr, 10'd20, ln);
            chk_bit("fetch enable", v, line_fetch_enable);
            if (q.size() < 15)
                push(seed ^ 16'h5A5A);
            raw(1'b0, 1'b0, 1'b1);
            half();
            chk_word("line pixel", {16'h0000, v ? q.pop_front() : {4'h0, fill}},
                     {16'h0000, lcd_data});
            raw(1'b0, 1'b0, 1'b0);
            half();
        end
        $display("test partial area done");
        part(1'b0, 1'b0, 10'd2, 12'h000);
        raw(1'b0, 1'b0, 1'b1);
        drain();
        for (int i = 0; i < 16; i++)
        begin
            seed = lfsr(seed);
            lastw = seed;
            push(seed);
        end
        @(negedge hclk);
        chk_bit("fifo full refuses", 1'b0, pix_ready);
        drain();
        chk_bit("fifo empty accepts", 1'b1, pix_ready);
        chk_word("panel latched", {16'h0000, lastw}, {16'h0000, last_px});
        half();
        chk_word("underflow holds", {16'h0000, lastw}, {16'h0000, lcd_data});
        half();
        raw(1'b0, 1'b0, 1'b0);
        ahb(1'b0, rpf_pkg::RPF_OFS_STATUS, 32'h0);
        chk_bit("underflow flag", 1'b1, rd[rpf_pkg::RPF_ST_UNDERFLOW_BIT]);
        ahb(1'b1, rpf_pkg::RPF_OFS_STATUS, 32'h00000001);
        ahb(1'b0, rpf_pkg::RPF_OFS_STATUS, 32'h0);
        chk_bit("underflow cleared", 1'b0, rd[rpf_pkg::RPF_ST_UNDERFLOW_BIT]);
        $display("test buffer done");
        conclude();
    end
endmodule : raster_polarity_and_partial_fill_test
`default_nettype wire
